/* File: core/dbls_top.sv */
`timescale 1ns/1ps

module dbls_top
	import dbls_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic nrst_i,
	// CPU local bus
	input wire logic cpu_req_i,
	input wire logic cpu_we_i,
	input wire logic [1:0] cpu_size_i,
	input wire dbls_class_t cpu_class_i,
	input wire logic [31:0] cpu_addr_i,
	input wire logic [31:0] cpu_wdata_i,
	output logic cpu_hit_o,
	output logic cpu_cache_discard_o,
	output logic cpu_stall_o,
	output logic cpu_ack_o,
	output logic cpu_err_o,
	output logic cpu_noncache_o,
	output logic [31:0] cpu_rdata_o,
	// DMA port
	input wire logic dma_req_i,
	input wire logic dma_we_i,
	input wire logic [1:0] dma_size_i,
	input wire logic [31:0] dma_addr_i,
	input wire logic [31:0] dma_wdata_i,
	output logic dma_hit_o,
	output logic dma_stall_o,
	output logic dma_ack_o,
	output logic dma_err_o,
	output logic [31:0] dma_rdata_o,
	// Control-register move (write only)
	input wire logic creg_we_i,
	input wire logic [11:0] creg_addr_i,
	input wire logic [31:0] creg_wdata_i,
	// Debug module port
	input wire logic dbg_we_i,
	input wire logic dbg_re_i,
	input wire logic [11:0] dbg_addr_i,
	input wire logic [31:0] dbg_wdata_i,
	output logic [31:0] dbg_rdata_o
);

	localparam int AW = $clog2(DBLS_BANK_WORDS);

	// ----------------------------------------------------------------
	// Base/configuration registers
	// ----------------------------------------------------------------
	logic [31:0] cfg_ff [2];
	logic [1:0] valid_ff;
	logic [1:0] cfg_we;
	logic [31:0] cfg_wdata;
	logic [31:0] cfg_rd [2];

	always_comb begin
		// Debug wins a same-cycle write with the move instruction
		cfg_wdata = dbg_we_i ? dbg_wdata_i : creg_wdata_i;
		cfg_we[0] = (dbg_we_i && dbg_addr_i == DBLS_CFG0_OFS) ||
			(!dbg_we_i && creg_we_i && creg_addr_i == DBLS_CFG0_OFS);
		cfg_we[1] = (dbg_we_i && dbg_addr_i == DBLS_CFG1_OFS) ||
			(!dbg_we_i && creg_we_i && creg_addr_i == DBLS_CFG1_OFS);
	end

	// Only valid is reset; the other bits survive a reset untouched
	always_ff @(posedge ref_clk_i) begin
		if (cfg_we[0]) begin
			cfg_ff[0] <= cfg_wdata & DBLS_WMASK0;
		end
		if (cfg_we[1]) begin
			cfg_ff[1] <= cfg_wdata & DBLS_WMASK1;
		end
	end

	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			valid_ff <= {2{DBLS_VALID_RST}};
		end else begin
			for (int a = 0; a < 2; a++) begin
				if (cfg_we[a]) begin
					valid_ff[a] <= cfg_wdata[DBLS_VALID_BIT];
				end
			end
		end
	end

	always_comb begin
		for (int a = 0; a < 2; a++) begin
			cfg_rd[a] = cfg_ff[a];
			cfg_rd[a][DBLS_VALID_BIT] = valid_ff[a];
		end
	end

	// Read back exists on the debug port only
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			dbg_rdata_o <= 32'h0;
		end else if (dbg_re_i && dbg_addr_i == DBLS_CFG0_OFS) begin
			dbg_rdata_o <= cfg_rd[0];
		end else if (dbg_re_i && dbg_addr_i == DBLS_CFG1_OFS) begin
			dbg_rdata_o <= cfg_rd[1];
		end else begin
			dbg_rdata_o <= 32'h0;
		end
	end

	// ----------------------------------------------------------------
	// Hit detection
	// ----------------------------------------------------------------
	logic [1:0] cpu_arr_hit;
	logic cpu_arr;
	logic cpu_wp_err;
	logic cpu_go;
	logic dma_go;
	logic dma_wp_err;

	always_comb begin
		for (int a = 0; a < 2; a++) begin
			cpu_arr_hit[a] = cpu_req_i && valid_ff[a] &&
				cpu_addr_i[31:16] == cfg_ff[a][31:DBLS_BASE_LSB] &&
				!cfg_ff[a][DBLS_MASK_LSB + 32'(cpu_class_i)];
		end
		// Overlapping windows resolve to array zero
		cpu_arr = !cpu_arr_hit[0];
		cpu_hit_o = |cpu_arr_hit;
		cpu_cache_discard_o = cpu_hit_o;
		cpu_wp_err = cpu_hit_o && cpu_we_i && cfg_ff[cpu_arr][DBLS_WP_BIT];
		cpu_go = cpu_hit_o && !cpu_wp_err;
		dma_hit_o = dma_req_i && valid_ff[1] && cfg_ff[1][DBLS_SPV_BIT] &&
			dma_addr_i[31:16] == cfg_ff[1][31:DBLS_BASE_LSB];
		dma_wp_err = dma_hit_o && dma_we_i && cfg_ff[1][DBLS_WP_BIT];
		dma_go = dma_hit_o && !dma_wp_err;
	end

	// ----------------------------------------------------------------
	// Byte enables (lane 3 is address offset 0)
	// ----------------------------------------------------------------
	function automatic logic [3:0] lanes(input logic [1:0] sz, input logic [1:0] ofs);
		logic [3:0] be;
		be = 4'hF;
		if (sz == DBLS_SZ_BYTE) begin
			be = 4'h8 >> ofs;
		end else if (sz == DBLS_SZ_WORD) begin
			be = ofs[1] ? 4'h3 : 4'hC;
		end
		return be;
	endfunction

	// ----------------------------------------------------------------
	// Banks: 0,1 array zero low/high; 2,3 array one low/high
	// ----------------------------------------------------------------
	logic [3:0] cpu_sel;
	logic [3:0] dma_sel;
	logic [3:0] dma_first;
	logic [3:0] dma_win;
	logic [3:0] cpu_win;
	logic [3:0] cpu_lost_ff;
	logic [3:0] dma_lost_ff;
	logic [31:0] bank_rdata [4];

	for (genvar g = 0; g < 4; g++) begin : g_bank
		logic pri_bit;
		logic p_en;
		logic p_we;
		logic [3:0] p_be;
		logic [AW-1:0] p_idx;
		logic [31:0] p_wdata;

		// Bank half picked by address bit 15
		assign cpu_sel[g] = cpu_go && cpu_arr == g[1] && cpu_addr_i[15] == g[0];
		assign dma_sel[g] = (g >= 2) && dma_go && dma_addr_i[15] == g[0];
		assign pri_bit = g[0] ? cfg_ff[1][DBLS_PRI_HI_BIT] : cfg_ff[1][DBLS_PRI_LO_BIT];

		// A requester stalled last cycle takes the bank now
		assign dma_first[g] = dma_lost_ff[g] || (!cpu_lost_ff[g] && pri_bit);
		assign dma_win[g] = dma_sel[g] && (!cpu_sel[g] || dma_first[g]);
		assign cpu_win[g] = cpu_sel[g] && !dma_win[g];

		always_comb begin
			p_en = cpu_win[g] || dma_win[g];
			p_we = dma_win[g] ? dma_we_i : cpu_we_i;
			p_be = dma_win[g] ? lanes(dma_size_i, dma_addr_i[1:0]) :
				lanes(cpu_size_i, cpu_addr_i[1:0]);
			p_idx = dma_win[g] ? dma_addr_i[AW+1:2] : cpu_addr_i[AW+1:2];
			p_wdata = dma_win[g] ? dma_wdata_i : cpu_wdata_i;
		end

		dbls_bank #(
			.WORDS(DBLS_BANK_WORDS),
			.AW(AW)
		) u_bank (
			.ref_clk_i(ref_clk_i),
			.en_i(p_en),
			.we_i(p_we),
			.be_i(p_be),
			.idx_i(p_idx),
			.wdata_i(p_wdata),
			.rdata_o(bank_rdata[g])
		);
	end

	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			cpu_lost_ff <= 4'h0;
			dma_lost_ff <= 4'h0;
		end else begin
			cpu_lost_ff <= cpu_sel & ~cpu_win;
			dma_lost_ff <= dma_sel & ~dma_win;
		end
	end

	always_comb begin
		cpu_stall_o = |(cpu_sel & ~cpu_win);
		dma_stall_o = |(dma_sel & ~dma_win);
	end

	// ----------------------------------------------------------------
	// Responses, one edge after the access is taken
	// ----------------------------------------------------------------
	logic [1:0] cpu_src_ff;
	logic dma_src_ff;
	logic cpu_rd_ff;

	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			cpu_ack_o <= 1'b0;
			cpu_err_o <= 1'b0;
			cpu_noncache_o <= 1'b0;
			cpu_rd_ff <= 1'b0;
			cpu_src_ff <= 2'h0;
		end else begin
			cpu_ack_o <= |cpu_win || cpu_wp_err;
			cpu_err_o <= cpu_wp_err;
			cpu_noncache_o <= |cpu_win;
			cpu_rd_ff <= |cpu_win && !cpu_we_i;
			cpu_src_ff <= {cpu_arr, cpu_addr_i[15]};
		end
	end

	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			dma_ack_o <= 1'b0;
			dma_err_o <= 1'b0;
			dma_src_ff <= 1'b0;
		end else begin
			dma_ack_o <= |dma_win || dma_wp_err;
			dma_err_o <= dma_wp_err;
			dma_src_ff <= dma_addr_i[15];
		end
	end

	// Read data comes straight from the bank output flops, so no extra wait
	always_comb begin
		cpu_rdata_o = cpu_rd_ff ? bank_rdata[cpu_src_ff] : 32'h0;
		dma_rdata_o = bank_rdata[{1'b1, dma_src_ff}];
	end

endmodule // dbls_top

/* File: pkg/dbls_pkg.sv */
package dbls_pkg;

	// ----------------------------------------------------------------
	// Configuration register map
	// ----------------------------------------------------------------
	localparam logic [11:0] DBLS_CFG0_OFS = 12'hC04;
	localparam logic [11:0] DBLS_CFG1_OFS = 12'hC05;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int DBLS_VALID_BIT = 0;
	localparam int DBLS_MASK_LSB = 1;
	localparam int DBLS_WP_BIT = 8;
	localparam int DBLS_SPV_BIT = 9;
	localparam int DBLS_PRI_LO_BIT = 10;
	localparam int DBLS_PRI_HI_BIT = 11;
	localparam int DBLS_BASE_LSB = 16;

	// Writable bits per array, valid (bit 0) aside; everything else reads as zero
	localparam logic [31:0] DBLS_WMASK0 = 32'hFFFFC13E;
	localparam logic [31:0] DBLS_WMASK1 = 32'hFFFFCF3E;

	// ----------------------------------------------------------------
	// Reset values and geometry
	// ----------------------------------------------------------------
	localparam logic DBLS_VALID_RST = 1'b0;
	localparam int DBLS_LINES = 2048;
	localparam int DBLS_LINE_BYTES = 16;
	localparam int DBLS_BANK_WORDS = DBLS_LINES * DBLS_LINE_BYTES / 4;

	// ----------------------------------------------------------------
	// Access sizes and reference classes
	// ----------------------------------------------------------------
	localparam logic [1:0] DBLS_SZ_BYTE = 2'h0;
	localparam logic [1:0] DBLS_SZ_WORD = 2'h1;

	typedef enum logic [2:0] {
		DBLS_CLS_UD,
		DBLS_CLS_UC,
		DBLS_CLS_SD,
		DBLS_CLS_SC,
		DBLS_CLS_IACK
	} dbls_class_t;

endpackage

/* File: core/dbls_bank.sv */
`timescale 1ns/1ps

module dbls_bank
	import dbls_pkg::*;
#(
	parameter int WORDS = DBLS_BANK_WORDS,
	parameter int AW = $clog2(WORDS)
) (
	// Clock
	input wire logic ref_clk_i,
	// Access port
	input wire logic en_i,
	input wire logic we_i,
	input wire logic [3:0] be_i,
	input wire logic [AW-1:0] idx_i,
	input wire logic [31:0] wdata_i,
	output logic [31:0] rdata_o
);

	// ----------------------------------------------------------------
	// Storage
	// ----------------------------------------------------------------
	// Contents are undefined after reset, so the array has no reset
	logic [31:0] rd_word;

	for (genvar b = 0; b < 4; b++) begin : g_lane
		// One store per byte lane, so every storage word has a single writer
		logic [7:0] lane_ff [WORDS];

		always_ff @(posedge ref_clk_i) begin
			if (en_i && we_i && be_i[b]) begin
				lane_ff[idx_i] <= wdata_i[8*b +: 8];
			end
		end

		assign rd_word[8*b +: 8] = lane_ff[idx_i];
	end

	always_ff @(posedge ref_clk_i) begin
		if (en_i) begin
			rdata_o <= rd_word;
		end
	end

endmodule // dbls_bank

/* File: test/dbls_checker.sv */
`timescale 1ns/1ps
module dbls_checker
	import dbls_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic nrst_i,
	// Watched ports
	input wire logic cpu_req_i,
	input wire logic cpu_hit_o,
	input wire logic cpu_cache_discard_o,
	input wire logic cpu_stall_o,
	input wire logic cpu_ack_o,
	input wire logic cpu_err_o,
	input wire logic cpu_noncache_o,
	input wire logic dma_req_i,
	input wire logic dma_hit_o,
	input wire logic dma_stall_o,
	input wire logic dma_ack_o,
	input wire logic [31:0] dbg_rdata_o
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!nrst_i);
	// A loser keeps its request up, so its turn comes one cycle late
	sequence s_cpu_lost;
		cpu_req_i && cpu_stall_o;
	endsequence
	sequence s_dma_lost;
		dma_req_i && dma_stall_o;
	endsequence
	a_discard_tracks_hit: assert property (cpu_cache_discard_o == cpu_hit_o)
		else $error("discard and hit differ");
	a_cpu_single_cycle: assert property (cpu_req_i && cpu_hit_o && !cpu_stall_o |=> cpu_ack_o)
		else $error("cpu ack late");
	a_ack_noncache: assert property (cpu_noncache_o == (cpu_ack_o && !cpu_err_o))
		else $error("noncache flag differs from data ack");
	a_err_with_ack: assert property (cpu_err_o |-> cpu_ack_o)
		else $error("error without ack");
	a_cpu_served_late: assert property (s_cpu_lost |=> !cpu_stall_o ##1 cpu_ack_o)
		else $error("stalled cpu not served");
	a_dma_served_late: assert property (s_dma_lost |=> !dma_stall_o ##1 dma_ack_o)
		else $error("stalled dma not served");
	a_single_loser: assert property (!(cpu_stall_o && dma_stall_o))
		else $error("both ports stalled");
	a_reset_no_hit: assert property ($rose(nrst_i) |-> !cpu_hit_o && !dma_hit_o)
		else $error("hit right after reset");
	a_reserved_zero: assert property ((dbg_rdata_o & ~DBLS_WMASK1 & 32'hFFFFFFFE) == 32'h0)
		else $error("reserved bit reads one");
endmodule // dbls_checker

bind dbls_top dbls_checker u_chk (.*);

/* File: test/dbls_dma_model.sv */
`timescale 1ns/1ps
module dbls_dma_model (
	// Clock
	input wire logic ref_clk_i,
	// Request side
	output logic dma_req_o = 1'b0,
	output logic dma_we_o = 1'b0,
	output logic [1:0] dma_size_o = 2'h2,
	output logic [31:0] dma_addr_o = 32'h0,
	output logic [31:0] dma_wdata_o = 32'h0,
	// Answer side
	input wire logic dma_hit_i,
	input wire logic dma_stall_i,
	input wire logic dma_ack_i,
	input wire logic [31:0] dma_rdata_i
);
	// Longword transfer held while stalled; gap idles first for a slow requester
	task automatic xfer(input logic we, input logic [31:0] a, input logic [31:0] wd,
		input int gap, output int st, output logic ok, output logic [31:0] rd);
		int i;
		st = 0;
		ok = 1'b0;
		repeat (gap + 1) @(negedge ref_clk_i);
		dma_we_o = we;
		dma_addr_o = a;
		dma_wdata_o = wd;
		dma_req_o = 1'b1;
		for (i = 0; i < 4 && !ok; i++) begin
			#1;
			if (!dma_hit_i) break;
			ok = !dma_stall_i;
			st += dma_stall_i;
			@(negedge ref_clk_i);
		end
		dma_req_o = 1'b0;
		// Flipped so a late sample of released data cannot pass by luck
		dma_wdata_o = ~wd;
		ok = ok && dma_ack_i;
		rd = dma_rdata_i;
	endtask
endmodule // dbls_dma_model

/* File: test/tb_dbls_top.sv */
`timescale 1ns/1ps
module tb_dbls_top;
	import dbls_pkg::*;
	logic ref_clk_i = 1'b0, nrst_i = 1'b0, cpu_req_i = 1'b0, cpu_we_i = 1'b0;
	logic creg_we_i = 1'b0, dbg_we_i = 1'b0, dbg_re_i = 1'b0;
	logic [1:0] cpu_size_i = 2'h2;
	dbls_class_t cpu_class_i = DBLS_CLS_SD;
	logic [31:0] cpu_addr_i = 32'h0, cpu_wdata_i = 32'h0, creg_wdata_i = 32'h0, dbg_wdata_i = 32'h0;
	logic [11:0] creg_addr_i = 12'h0, dbg_addr_i = 12'h0;
	logic dma_req_i, dma_we_i, dma_hit_o, dma_stall_o, dma_ack_o, dma_err_o;
	logic cpu_hit_o, cpu_cache_discard_o, cpu_stall_o, cpu_ack_o, cpu_err_o, cpu_noncache_o;
	logic [1:0] dma_size_i;
	logic [31:0] dma_addr_i, dma_wdata_i, cpu_rdata_o, dma_rdata_o, dbg_rdata_o, d, d2;
	logic h, ok;
	int s, s2, k, j;
	int n_fail = 0;
	int tests_run = 0;
	always #5 ref_clk_i = ~ref_clk_i;
	dbls_top uut (.*);
	dbls_dma_model u_dma (.ref_clk_i(ref_clk_i), .dma_req_o(dma_req_i), .dma_we_o(dma_we_i),
		.dma_size_o(dma_size_i), .dma_addr_o(dma_addr_i), .dma_wdata_o(dma_wdata_i),
		.dma_hit_i(dma_hit_o), .dma_stall_i(dma_stall_o), .dma_ack_i(dma_ack_o),
		.dma_rdata_i(dma_rdata_o));
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic end_sim();
		$display("checks %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task automatic wr_cfg(input logic dbg, input logic [11:0] a, input logic [31:0] v);
		@(negedge ref_clk_i);
		dbg_we_i = dbg;
		creg_we_i = !dbg;
		dbg_addr_i = a;
		creg_addr_i = a;
		dbg_wdata_i = v;
		creg_wdata_i = v;
		@(negedge ref_clk_i);
		dbg_we_i = 1'b0;
		creg_we_i = 1'b0;
	endtask
	task automatic rd_cfg(input logic [11:0] a);
		@(negedge ref_clk_i);
		dbg_re_i = 1'b1;
		dbg_addr_i = a;
		@(negedge ref_clk_i);
		dbg_re_i = 1'b0;
		d = dbg_rdata_o;
	endtask
	task automatic cpu_acc(input logic we, input logic [1:0] sz, input logic [31:0] a,
		input logic [31:0] wd);
		int i;
		@(negedge ref_clk_i);
		cpu_req_i = 1'b1;
		cpu_we_i = we;
		cpu_size_i = sz;
		cpu_addr_i = a;
		cpu_wdata_i = wd;
		h = 1'b0;
		s = 0;
		for (i = 0; i < 4 && !h; i++) begin
			#1;
			if (!cpu_hit_o) break;
			h = !cpu_stall_o;
			s += cpu_stall_o;
			@(negedge ref_clk_i);
		end
		if (!h && i == 4) begin
			chk("cpu served", 32'h1, 32'h0);
			end_sim();
		end
		cpu_req_i = 1'b0;
		cpu_wdata_i = ~wd;
		d = cpu_rdata_o;
		if (h) chk("cpu ack", 32'h1, cpu_ack_o);
	endtask
	// --------
	// Scenarios
	// --------
	task automatic t_regs();
		cpu_acc(1'b0, 2'h2, 32'h20000000, 32'h0);
		chk("hit while invalid", 32'h0, h);
		wr_cfg(1'b1, DBLS_CFG0_OFS, 32'hFFFFFFFF);
		rd_cfg(DBLS_CFG0_OFS);
		chk("cfg0 mask", DBLS_WMASK0 | 32'h1, d);
		wr_cfg(1'b1, DBLS_CFG1_OFS, 32'hFFFFFFFF);
		rd_cfg(DBLS_CFG1_OFS);
		chk("cfg1 mask", DBLS_WMASK1 | 32'h1, d);
		wr_cfg(1'b0, DBLS_CFG0_OFS, 32'h20000001);
		rd_cfg(DBLS_CFG0_OFS);
		chk("cfg0 by move", 32'h20000001, d);
	endtask
	task automatic t_data();
		cpu_acc(1'b1, 2'h2, 32'h20000000, 32'h11223344);
		cpu_acc(1'b1, DBLS_SZ_BYTE, 32'h20000001, 32'h00AA0000);
		cpu_acc(1'b1, DBLS_SZ_WORD, 32'h20000002, 32'h0000BBCC);
		cpu_acc(1'b0, 2'h2, 32'h20000000, 32'h0);
		chk("lane merge", 32'h11AABBCC, d);
		cpu_acc(1'b0, 2'h2, 32'h2000FFFC, 32'h0);
		chk("window top", 32'h1, h);
		cpu_acc(1'b0, 2'h2, 32'h20010000, 32'h0);
		chk("past window", 32'h0, h);
	endtask
	task automatic t_wp();
		wr_cfg(1'b1, DBLS_CFG0_OFS, 32'h20000101);
		cpu_acc(1'b1, 2'h2, 32'h20000000, 32'h5A5A5A5A);
		chk("wp error", 32'h1, cpu_err_o);
		cpu_acc(1'b0, 2'h2, 32'h20000000, 32'h0);
		chk("wp kept data", 32'h11AABBCC, d);
	endtask
	task automatic t_mask();
		for (k = 0; k < 5; k++) begin
			wr_cfg(1'b1, DBLS_CFG0_OFS, 32'h20000001 | (32'h2 << k));
			cpu_class_i = dbls_class_t'(k);
			cpu_acc(1'b0, 2'h2, 32'h20000000, 32'h0);
			chk("masked class", 32'h0, h);
			cpu_class_i = dbls_class_t'((k + 1) % 5);
			cpu_acc(1'b0, 2'h2, 32'h20000000, 32'h0);
			chk("open class", 32'h1, h);
		end
	endtask
	task automatic t_reset();
		wr_cfg(1'b1, DBLS_CFG0_OFS, 32'h20000123);
		nrst_i = 1'b0;
		@(negedge ref_clk_i);
		nrst_i = 1'b1;
		rd_cfg(DBLS_CFG0_OFS);
		chk("reset keeps fields", 32'h20000122, d);
		wr_cfg(1'b1, DBLS_CFG0_OFS, 32'h20000001);
	endtask
	task automatic t_dma();
		wr_cfg(1'b0, DBLS_CFG1_OFS, 32'h30000201);
		u_dma.xfer(1'b0, 32'h20000000, 32'h0, 0, s2, ok, d2);
		chk("dma to array zero", 32'h0, ok);
		u_dma.xfer(1'b1, 32'h30000010, 32'hCAFEF00D, 2, s2, ok, d2);
		chk("dma write taken", 32'h1, ok);
		cpu_acc(1'b0, 2'h2, 32'h30000010, 32'h0);
		chk("dma written data", 32'hCAFEF00D, d);
		wr_cfg(1'b1, DBLS_CFG1_OFS, 32'h30000301);
		u_dma.xfer(1'b1, 32'h30000010, 32'h0, 0, s2, ok, d2);
		chk("dma wp error", 32'h1, dma_err_o);
		u_dma.xfer(1'b0, 32'h30000010, 32'h0, 0, s2, ok, d2);
		chk("dma read data", 32'hCAFEF00D, d2);
		for (k = 0; k < 4; k++) begin
			wr_cfg(1'b1, DBLS_CFG1_OFS, 32'h30000201 | (k << 10));
			for (j = 0; j < 2; j++) begin
				fork
					cpu_acc(1'b0, 2'h2, 32'h30000000 | (j << 15), 32'h0);
					u_dma.xfer(1'b1, 32'h30000004 | (j << 15), 32'h0, 0, s2, ok, d2);
				join
				chk("cpu stall", j ? k[1] : k[0], s);
				chk("single stall", 32'h1, s + s2);
				chk("dma served", 32'h1, ok);
			end
		end
		fork
			cpu_acc(1'b0, 2'h2, 32'h30000000, 32'h0);
			u_dma.xfer(1'b0, 32'h30008000, 32'h0, 0, s2, ok, d2);
		join
		chk("split banks", 32'h0, s + s2);
	endtask
	initial begin
		repeat (3) @(negedge ref_clk_i);
		nrst_i = 1'b1;
		t_regs();
		t_data();
		t_wp();
		t_mask();
		t_reset();
		t_dma();
		end_sim();
	end
endmodule // tb_dbls_top
